// ---- rtl/motor_fault_response_manager.sv ----
// Purpose: Fault response manager: current limit, thermal and stall handling.
// Assumes: Comparator pins are asynchronous; ADC and estimator data are on clk.
// Notes: Outputs are registered, so pin and FET reactions lag their cause by one cycle.
`default_nettype none

module motor_fault_response_manager #(
  parameter int unsigned NO_LOAD_CYCLES = fault_pkg::NO_LOAD_CYCLES,
  parameter int unsigned RETRY_UNIT_CYCLES = fault_pkg::RETRY_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] rdata,
  input wire logic current_over_limit,
  input wire logic [15:0] measured_speed,
  input wire logic [15:0] backemf_estimated,
  input wire logic [15:0] backemf_expected,
  input wire fault_pkg::phase_current_type phase_current,
  input wire logic measure_active,
  input wire logic [15:0] measured_backemf,
  input wire logic heat_warning_pin,
  input wire logic fet_thermal_shutdown,
  input wire logic regulator_thermal_pin,
  input wire logic fault_pin_n_in,
  output logic fault_pin_n_out,
  output logic fault_pin_n_oe,
  output fault_pkg::fet_state_type fet_state,
  output logic charge_pump_enable
);
  typedef struct packed {
    logic [fault_pkg::PIN_COUNT-1:0] sync1;
    logic [fault_pkg::PIN_COUNT-1:0] sync2;
    logic [fault_pkg::PIN_COUNT-1:0] sync3;
    logic [fault_pkg::PIN_COUNT-1:0] pins;
    fault_pkg::control_type ctrl;
    logic [15:0] overspeed_threshold;
    logic [15:0] backemf_mismatch_threshold;
    logic [11:0] missing_load_current_threshold;
    logic [15:0] backemf_detect_threshold;
    logic clear_pulse;
    logic [fault_pkg::LOAD_CNT_WIDTH-1:0] load_cnt;
    logic heat_warning_flag;
    logic thermal_event_flag;
    logic shutdown_latched_flag;
    logic param_measure_backemf_fault;
    logic overspeed_lock;
    logic backemf_mismatch_lock;
    logic missing_load_lock;
    fault_pkg::fet_state_type fet;
    logic pump;
    logic fault_oe;
    logic [31:0] rdata;
  } core_state_type;

  core_state_type q;
  core_state_type next_q;
  fault_pkg::status_type status;
  logic warn_level;
  logic shut_level;
  logic wipe;
  logic [15:0] bemf_diff;
  logic overspeed_hit;
  logic mismatch_hit;
  logic low_current;
  logic missing_hit;
  logic stall_condition;
  logic measure_hit;
  logic [31:0] retry_cycles;
  logic cl_active;
  logic cl_fault;
  logic cl_release;
  fault_pkg::fet_state_type cl_fet;
  logic st_active;
  logic st_fault;
  logic st_release;
  fault_pkg::fet_state_type st_fet;

  ////////////////////////////////////////////////////////////////////////////
  // Detectors

  assign warn_level = q.pins[fault_pkg::PIN_WARN];
  assign shut_level = q.pins[fault_pkg::PIN_SHUT];
  // Regulator overheat acts as a reset of all fault state
  assign wipe = q.pins[fault_pkg::PIN_REG];

  assign overspeed_hit = q.ctrl.overspeed_detect_enable
    && measured_speed > q.overspeed_threshold;

  always_comb begin
    if (backemf_estimated >= backemf_expected) begin
      bemf_diff = backemf_estimated - backemf_expected;
    end else begin
      bemf_diff = backemf_expected - backemf_estimated;
    end
  end

  assign mismatch_hit = q.ctrl.backemf_detect_enable
    && bemf_diff > q.backemf_mismatch_threshold;

  assign low_current = phase_current.phase_a < q.missing_load_current_threshold
    || phase_current.phase_b < q.missing_load_current_threshold
    || phase_current.phase_c < q.missing_load_current_threshold;

  assign missing_hit = q.ctrl.missing_load_detect_enable && low_current
    && q.load_cnt == fault_pkg::LOAD_CNT_WIDTH'(NO_LOAD_CYCLES);

  assign stall_condition = overspeed_hit || mismatch_hit || missing_hit;

  assign measure_hit = measure_active
    && measured_backemf < q.backemf_detect_threshold;

  assign retry_cycles = (32'(q.ctrl.retry_time_setting) + 32'h1) * 32'(RETRY_UNIT_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Response channels

  fault_response_channel current_limit_channel (
    .clk(clk),
    .resetn(resetn),
    .wipe(wipe),
    .condition(current_over_limit),
    .code(q.ctrl.current_limit_response_code),
    .clear_pulse(q.clear_pulse),
    .retry_cycles(retry_cycles),
    .active(cl_active),
    .fault(cl_fault),
    .release_now(cl_release),
    .fet(cl_fet)
  );

  fault_response_channel stall_channel (
    .clk(clk),
    .resetn(resetn),
    .wipe(wipe),
    .condition(stall_condition),
    .code(q.ctrl.stall_response_code),
    .clear_pulse(q.clear_pulse),
    .retry_cycles(retry_cycles),
    .active(st_active),
    .fault(st_fault),
    .release_now(st_release),
    .fet(st_fet)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  always_comb begin
    status = '0;
    status.controller_fault = cl_active || st_active;
    status.driver_fault = shut_level;
    status.adc_current_limit_flag = cl_active;
    status.heat_warning_flag = q.heat_warning_flag;
    status.thermal_event_flag = q.thermal_event_flag;
    status.shutdown_latched_flag = q.shutdown_latched_flag;
    status.rotor_stall_flag = st_active;
    status.overspeed_lock = q.overspeed_lock;
    status.backemf_mismatch_lock = q.backemf_mismatch_lock;
    status.missing_load_lock = q.missing_load_lock;
    status.param_measure_backemf_fault = q.param_measure_backemf_fault;
    status.fault_pin_level = q.pins[fault_pkg::PIN_FAULT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q = q;

    // Pin inputs: a change counts once the last two stages agree
    next_q.sync1 = {fault_pin_n_in, regulator_thermal_pin, fet_thermal_shutdown, heat_warning_pin};
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    for (int i = 0; i < fault_pkg::PIN_COUNT; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        next_q.pins[i] = q.sync3[i];
      end
    end

    // Register writes; the clear bit is never stored, only pulsed
    next_q.clear_pulse = 1'b0;
    if (write_strobe) begin
      case (addr)
        fault_pkg::CTRL_ADDR: begin
          next_q.ctrl = fault_pkg::control_type'(wdata);
          next_q.ctrl.clear_fault_command = 1'b0;
          next_q.ctrl.unused = '0;
          next_q.clear_pulse = wdata[fault_pkg::CLEAR_BIT];
        end
        fault_pkg::SPEED_THR_ADDR: begin
          next_q.overspeed_threshold = wdata[15:0];
        end
        fault_pkg::MISMATCH_THR_ADDR: begin
          next_q.backemf_mismatch_threshold = wdata[15:0];
        end
        fault_pkg::LOAD_THR_ADDR: begin
          next_q.missing_load_current_threshold = wdata[11:0];
        end
        fault_pkg::DETECT_THR_ADDR: begin
          next_q.backemf_detect_threshold = wdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // Reads answer in the next cycle only; unmapped reads give zero
    next_q.rdata = 32'h0;
    if (read_strobe) begin
      case (addr)
        fault_pkg::CTRL_ADDR: next_q.rdata = 32'(q.ctrl);
        fault_pkg::SPEED_THR_ADDR: next_q.rdata = 32'(q.overspeed_threshold);
        fault_pkg::MISMATCH_THR_ADDR: next_q.rdata = 32'(q.backemf_mismatch_threshold);
        fault_pkg::LOAD_THR_ADDR: next_q.rdata = 32'(q.missing_load_current_threshold);
        fault_pkg::DETECT_THR_ADDR: next_q.rdata = 32'(q.backemf_detect_threshold);
        fault_pkg::STATUS_ADDR: next_q.rdata = 32'(status);
        default: next_q.rdata = 32'h0;
      endcase
    end

    // Missing load timer saturates so the event holds while current stays low
    if (q.ctrl.missing_load_detect_enable && low_current) begin
      if (!missing_hit) begin
        next_q.load_cnt = q.load_cnt + 1'b1;
      end
    end else begin
      next_q.load_cnt = '0;
    end

    // Detector flags follow the stall channel: set on event, drop with release
    if (st_release) begin
      next_q.overspeed_lock = 1'b0;
      next_q.backemf_mismatch_lock = 1'b0;
      next_q.missing_load_lock = 1'b0;
    end
    if (st_active || !q.ctrl.stall_response_code[3] ||
        q.ctrl.stall_response_code == fault_pkg::REPORT_CODE) begin
      if (overspeed_hit) next_q.overspeed_lock = 1'b1;
      if (mismatch_hit) next_q.backemf_mismatch_lock = 1'b1;
      if (missing_hit) next_q.missing_load_lock = 1'b1;
    end

    // Thermal and measurement flags: set wins over a clear arriving in the same cycle
    if (q.clear_pulse && !warn_level) begin
      next_q.heat_warning_flag = 1'b0;
    end
    if (warn_level && q.ctrl.heat_warning_report_enable) begin
      next_q.heat_warning_flag = 1'b1;
    end
    if (q.clear_pulse && !warn_level && !shut_level) begin
      next_q.thermal_event_flag = 1'b0;
    end
    if ((warn_level && q.ctrl.heat_warning_report_enable) || shut_level) begin
      next_q.thermal_event_flag = 1'b1;
    end
    if (q.clear_pulse && !shut_level) begin
      next_q.shutdown_latched_flag = 1'b0;
    end
    if (shut_level) begin
      next_q.shutdown_latched_flag = 1'b1;
    end
    if (q.clear_pulse && !measure_hit) begin
      next_q.param_measure_backemf_fault = 1'b0;
    end
    if (measure_hit) begin
      next_q.param_measure_backemf_fault = 1'b1;
    end

    // Output stage: shutdown first, then current limit, then stall
    if (shut_level) begin
      next_q.fet = fault_pkg::FET_ALL_OFF;
    end else if (cl_fault) begin
      next_q.fet = cl_fet;
    end else if (st_fault) begin
      next_q.fet = st_fet;
    end else begin
      next_q.fet = fault_pkg::FET_NORMAL;
    end
    next_q.pump = !shut_level;
    next_q.fault_oe = cl_fault || st_fault || q.heat_warning_flag || shut_level;

    if (wipe) begin
      next_q.heat_warning_flag = 1'b0;
      next_q.thermal_event_flag = 1'b0;
      next_q.shutdown_latched_flag = 1'b0;
      next_q.param_measure_backemf_fault = 1'b0;
      next_q.overspeed_lock = 1'b0;
      next_q.backemf_mismatch_lock = 1'b0;
      next_q.missing_load_lock = 1'b0;
      next_q.load_cnt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.ctrl <= fault_pkg::control_type'(fault_pkg::CTRL_RESET);
      q.overspeed_threshold <= fault_pkg::THR_RESET;
      q.backemf_mismatch_threshold <= fault_pkg::THR_RESET;
      q.missing_load_current_threshold <= fault_pkg::LOAD_THR_RESET;
      q.backemf_detect_threshold <= fault_pkg::DETECT_THR_RESET;
      {q.sync1, q.sync2, q.sync3, q.pins} <= {4{fault_pkg::PIN_IDLE}}; // Fault wire idles high
      q.pump <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign fault_pin_n_out = 1'b0;
  assign fault_pin_n_oe = q.fault_oe;
  assign fet_state = q.fet;
  assign charge_pump_enable = q.pump;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  shutdown_fets_off_a: assert property (
    shut_level |=> fet_state == fault_pkg::FET_ALL_OFF && !charge_pump_enable && fault_pin_n_oe)
    else $error("shutdown did not stop the output stage");

  shutdown_flag_hold_a: assert property (
    q.shutdown_latched_flag && !(q.clear_pulse && !shut_level) && !wipe
    |=> q.shutdown_latched_flag)
    else $error("shutdown flag dropped without clear");

  warn_pin_low_a: assert property (
    q.heat_warning_flag |=> fault_pin_n_oe)
    else $error("warning flag set but fault pin released");

  warn_set_a: assert property (
    warn_level && q.ctrl.heat_warning_report_enable && !wipe
    |=> q.heat_warning_flag && q.thermal_event_flag)
    else $error("heat warning not reported");

  clear_keeps_active_a: assert property (
    q.clear_pulse && shut_level && !wipe |=> q.shutdown_latched_flag)
    else $error("clear removed a flag whose cause remains");

  wipe_flags_a: assert property (
    wipe |=> !q.heat_warning_flag && !q.shutdown_latched_flag && !q.param_measure_backemf_fault
    ##0 !cl_active && !st_active)
    else $error("regulator overheat left flags set");

  overspeed_lock_a: assert property (
    overspeed_hit && q.ctrl.stall_response_code[3:2] == 2'h0 && !st_active && !wipe
    |=> st_active && q.overspeed_lock ##1 fault_pin_n_oe)
    else $error("overspeed did not raise a stall");

  missing_load_a: assert property (
    missing_hit |-> q.load_cnt == fault_pkg::LOAD_CNT_WIDTH'(NO_LOAD_CYCLES) && low_current)
    else $error("missing load raised before its time");

  measure_fault_a: assert property (
    measure_hit && !wipe |=> q.param_measure_backemf_fault)
    else $error("measurement back-EMF fault missed");

  report_running_a: assert property (
    cl_active && !cl_fault && !st_fault && !shut_level |=> fet_state == fault_pkg::FET_NORMAL)
    else $error("report-only mode disturbed the drivers");
endmodule // motor_fault_response_manager

`default_nettype wire

// ---- rtl/fault_pkg.sv ----
// Purpose: Shared constants and types for the motor fault response manager.
// Assumes: 40 MHz clock; analog comparators supply already hysteretic levels.
`default_nettype none

package fault_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NO_LOAD_MS = 500;
  localparam int unsigned NO_LOAD_CYCLES = NO_LOAD_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_UNIT_MS = 100;
  localparam int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_HZ / 1000);
  localparam int LOAD_CNT_WIDTH = 25;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] SPEED_THR_ADDR = 8'h04;
  localparam logic [7:0] MISMATCH_THR_ADDR = 8'h08;
  localparam logic [7:0] LOAD_THR_ADDR = 8'h0c;
  localparam logic [7:0] DETECT_THR_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h14;

  localparam int CLEAR_BIT = 16;
  localparam logic [3:0] REPORT_CODE = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] THR_RESET = 16'hffff;
  localparam logic [11:0] LOAD_THR_RESET = 12'h000;
  localparam logic [15:0] DETECT_THR_RESET = 16'h0000;

  localparam int PIN_WARN = 0;
  localparam int PIN_SHUT = 1;
  localparam int PIN_REG = 2;
  localparam int PIN_FAULT = 3;
  localparam int PIN_COUNT = 4;
  // Idle levels of the synchronised pins: only the fault wire rests high
  localparam logic [3:0] PIN_IDLE = 4'h8;

  typedef enum logic [1:0] {
    FET_NORMAL = 2'h0,
    FET_ALL_OFF = 2'h1,
    FET_HIGH_ON = 2'h2,
    FET_LOW_ON = 2'h3
  } fet_state_type;

  typedef enum logic [3:0] {
    CH_IDLE = 4'h1,
    CH_LATCHED = 4'h2,
    CH_RETRY = 4'h4,
    CH_REPORT = 4'h8
  } channel_state_type;

  typedef struct packed {
    logic [11:0] phase_a;
    logic [11:0] phase_b;
    logic [11:0] phase_c;
  } phase_current_type;

  typedef struct packed {
    logic [14:0] unused;
    logic clear_fault_command;
    logic missing_load_detect_enable;
    logic backemf_detect_enable;
    logic overspeed_detect_enable;
    logic heat_warning_report_enable;
    logic [3:0] retry_time_setting;
    logic [3:0] stall_response_code;
    logic [3:0] current_limit_response_code;
  } control_type;

  typedef struct packed {
    logic [19:0] unused;
    logic fault_pin_level;
    logic param_measure_backemf_fault;
    logic missing_load_lock;
    logic backemf_mismatch_lock;
    logic overspeed_lock;
    logic rotor_stall_flag;
    logic shutdown_latched_flag;
    logic thermal_event_flag;
    logic heat_warning_flag;
    logic adc_current_limit_flag;
    logic driver_fault;
    logic controller_fault;
  } status_type;
endpackage

`default_nettype wire

// ---- rtl/fault_response_channel.sv ----
// Purpose: One four-mode response channel (latched, retry, report, disabled).
// Assumes: condition is a level from logic on the same clock.
// Notes: Code is captured at recognition so a rewrite cannot change the FET state mid-event.
`default_nettype none

module fault_response_channel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wipe,
  input wire logic condition,
  input wire logic [3:0] code,
  input wire logic clear_pulse,
  input wire logic [31:0] retry_cycles,
  output logic active,
  output logic fault,
  output logic release_now,
  output fault_pkg::fet_state_type fet
);
  typedef struct packed {
    fault_pkg::channel_state_type state;
    logic [31:0] timer;
    logic [3:0] code;
  } channel_type;

  channel_type q;
  channel_type next_q;
  logic is_latched;
  logic is_retry;
  logic is_report;

  assign is_latched = code[3:2] == 2'h0;
  assign is_retry = code[3:2] == 2'h1;
  assign is_report = code == fault_pkg::REPORT_CODE;

  always_comb begin
    next_q = q;
    release_now = 1'b0;
    case (q.state)
      fault_pkg::CH_IDLE: begin
        // Codes outside the listed ones act as disabled
        next_q.code = code;
        next_q.timer = 32'h1;
        if (condition && is_latched) begin
          next_q.state = fault_pkg::CH_LATCHED;
        end else if (condition && is_retry) begin
          next_q.state = fault_pkg::CH_RETRY;
        end else if (condition && is_report) begin
          next_q.state = fault_pkg::CH_REPORT;
        end
      end
      fault_pkg::CH_LATCHED, fault_pkg::CH_REPORT: begin
        if (clear_pulse && !condition) begin
          release_now = 1'b1;
          next_q.state = fault_pkg::CH_IDLE;
        end
      end
      fault_pkg::CH_RETRY: begin
        next_q.timer = q.timer + 32'h1;
        if (q.timer >= retry_cycles) begin
          release_now = 1'b1;
          next_q.state = fault_pkg::CH_IDLE;
        end
      end
      default: begin
        next_q.state = fault_pkg::CH_IDLE;
      end
    endcase
    if (wipe) begin
      next_q.state = fault_pkg::CH_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q.state <= fault_pkg::CH_IDLE;
      q.timer <= 32'h0;
      q.code <= 4'h0;
    end else begin
      q <= next_q;
    end
  end

  assign active = q.state != fault_pkg::CH_IDLE;
  assign fault = q.state == fault_pkg::CH_LATCHED || q.state == fault_pkg::CH_RETRY;

  always_comb begin
    if (!fault || !q.code[1]) begin
      fet = fault_pkg::FET_ALL_OFF;
    end else if (q.code[0]) begin
      fet = fault_pkg::FET_LOW_ON;
    end else begin
      fet = fault_pkg::FET_HIGH_ON;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  latched_hold_a: assert property (
    q.state == fault_pkg::CH_LATCHED && !(clear_pulse && !condition) && !wipe
    |=> q.state == fault_pkg::CH_LATCHED)
    else $error("latched channel left without clear");

  retry_wait_a: assert property (
    q.state == fault_pkg::CH_RETRY && q.timer < retry_cycles && !wipe
    |=> q.state == fault_pkg::CH_RETRY && q.timer == $past(q.timer) + 32'h1)
    else $error("retry ended early");

  retry_end_a: assert property (
    q.state == fault_pkg::CH_RETRY && q.timer >= retry_cycles
    |=> q.state == fault_pkg::CH_IDLE ##0 !fault)
    else $error("retry did not end on time");

  report_quiet_a: assert property (
    q.state == fault_pkg::CH_REPORT |-> !fault && active)
    else $error("report mode raised protective action");

  disabled_idle_a: assert property (
    q.state == fault_pkg::CH_IDLE && code[3] && code[0] |=> q.state == fault_pkg::CH_IDLE)
    else $error("disabled code reacted");

  fet_code_a: assert property (
    fault && q.code[1:0] == 2'h2 |-> fet == fault_pkg::FET_HIGH_ON)
    else $error("wrong FET state for code");
endmodule // fault_response_channel

`default_nettype wire

// ---- testbench/fault_line_model.sv ----
// Purpose: Far-side model: pull-up on the fault wire and a watching controller.
// Assumes: The device side only ever pulls the wire low.
// Notes: Counts low cycles so the controller could react to reports.
`default_nettype none
module fault_line_model (
  input wire logic clk,
  input wire logic pull_low,
  output logic level,
  output int low_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level = pull_low ? 1'b0 : 1'b1;
  initial low_cycles = 0;
  // Report-only never pulls the wire low; every low cycle from the other faults is noticed
  always @(posedge clk) if (!level) low_cycles <= low_cycles + 1;
endmodule // fault_line_model
`default_nettype wire

// ---- testbench/motor_fault_response_manager_bench.sv ----
// Purpose: Self-checking bench for the fault response manager.
// Assumes: Retry unit 8 cycles, no-load count 20 cycles.
// Notes: Expectations come from a small mode table.
`default_nettype none
module motor_fault_response_manager_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, ws = 0, rs = 0, ovl = 0, hot = 0, shut = 0, pin_n, oe, cp, pout;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, st, e;
  logic reg_hot = 0, meas = 0;
  logic [15:0] spd = 16'h0;
  fault_pkg::phase_current_type ph = '0;
  fault_pkg::fet_state_type fet;
  int bad_count = 0, compares = 0, lows;
  always #12.5 clk = ~clk;
  motor_fault_response_manager #(.NO_LOAD_CYCLES(20), .RETRY_UNIT_CYCLES(8)) u_motor_fault_response_manager (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .write_strobe(ws), .read_strobe(rs),
    .rdata(rdata), .current_over_limit(ovl), .measured_speed(spd), .backemf_estimated(spd),
    .backemf_expected(16'h0000), .phase_current(ph), .measure_active(meas), .measured_backemf(spd),
    .heat_warning_pin(hot), .fet_thermal_shutdown(shut), .regulator_thermal_pin(reg_hot),
    .fault_pin_n_in(pin_n), .fault_pin_n_out(pout), .fault_pin_n_oe(oe), .fet_state(fet), .charge_pump_enable(cp));
  fault_line_model u_fault_line_model (.clk(clk), .pull_low(oe), .level(pin_n), .low_cycles(lows));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrx(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
  endtask
  task automatic wr(logic [31:0] d);
    wrx(8'h00, d);
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    // Read data stand only in the cycle after the strobe; take them at its closing edge
    @(posedge clk);
    st = rdata;
  endtask
  task automatic complete_run();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hbe196768));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h14);
    chk("status", 32'h800, st);
    rd(8'h40);
    chk("unmapped", 32'h0, st);
    for (int c = 0; c < 10; c++) begin
      wr(c);
      spd <= 16'($urandom);
      ovl <= 1'b1;
      // Pin level needs the synchroniser before status shows it low
      repeat (6) @(posedge clk);
      chk("fet", c > 7 ? 0 : (c[1] ? 2 + c[0] : 1), fet);
      chk("pin", c < 8, oe);
      e = c < 8 ? 32'h5 : (c == 8 ? 32'h805 : 32'h800);
      rd(8'h14);
      chk("flags", e, st);
      if (c < 4 || c == 8) begin
        wr(c | 32'h10000);
        rd(8'h14);
        chk("held", e, st);
      end
      ovl <= 1'b0;
      repeat (12) @(posedge clk);
      rd(8'h14);
      chk("after", c < 4 || c == 8 ? e : 32'h800, st);
      wr(c | 32'h10000);
      repeat (6) @(posedge clk);
      rd(8'h14);
      chk("cleared", 32'h800, st);
    end
    chk("pin drive", 32'h0, pout);
    shut <= 1'b1;
    repeat (8) @(posedge clk);
    chk("shutdown", 32'h3, {cp, fet, oe});
    rd(8'h14);
    chk("shut flags", 32'h22, 32'h822 & st);
    shut <= 1'b0;
    repeat (8) @(posedge clk);
    chk("resume", 32'h8, {cp, fet, oe});
    rd(8'h14);
    chk("shut held", 32'h820, 32'h822 & st);
    wr(32'h11000);
    hot <= 1'b1;
    repeat (10) @(posedge clk);
    chk("warn", 32'h9, {cp, fet, oe});
    rd(8'h14);
    chk("warn flags", 32'h18, 32'h838 & st);
    hot <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'h14);
    chk("warn held", 32'h18, 32'h818 & st);
    wr(32'h11000);
    repeat (6) @(posedge clk);
    rd(8'h14);
    chk("warn clear", 32'h800, st);
    // Overspeed with a zero threshold: any nonzero speed trips it
    wrx(8'h04, 32'h0);
    spd <= 16'($urandom) | 16'h1;
    wr(32'h2000);
    repeat (5) @(posedge clk);
    rd(8'h14);
    chk("overspeed", 32'h0c1, st);
    wr(32'h10000);
    repeat (6) @(posedge clk);
    rd(8'h14);
    chk("overspeed clear", 32'h800, st);
    // Missing load in auto-retry: phases at zero stay under the threshold
    wrx(8'h0c, 32'h100);
    wr(32'h8040);
    repeat (30) @(posedge clk);
    rd(8'h14);
    chk("missing load", 32'h241, st);
    ph <= {3{12'hfff}};
    repeat (14) @(posedge clk);
    rd(8'h14);
    chk("retry release", 32'h800, st);
    // Measurement fault beside a latched limit, then regulator overheat wipes all
    wr(32'h0);
    wrx(8'h10, 32'hffff);
    spd <= 16'($urandom) & 16'h7fff;
    meas <= 1'b1;
    ovl <= 1'b1;
    repeat (8) @(posedge clk);
    rd(8'h14);
    chk("measure", 32'h405, st);
    meas <= 1'b0;
    reg_hot <= 1'b1;
    repeat (12) @(posedge clk);
    rd(8'h14);
    chk("wipe", 32'h800, st);
    ovl <= 1'b0;
    reg_hot <= 1'b0;
    chk("model saw low", 32'h1, 32'(lows > 0));
    complete_run();
  end
  initial begin
    #200us;
    bad_count++;
    complete_run();
  end
endmodule // motor_fault_response_manager_bench
`default_nettype wire
